// file: core/transfer_controller_core.sv
// Contract
// - Request bus on activation; release after everything
// - Arbiter ranks this controller above CPU
// - Owner keeps bus until acknowledge withdrawn
// - CPU yields only between whole bus cycles
// - Sleeping CPU yields the bus immediately
// - Started by enabled interrupt or software
// - Descriptors in RAM window, 32-bit, one state
// - Load descriptor, transfer, write it back
// - Working registers invisible to the CPU
// - Source step: fixed, increment, decrement
// - Destination step: fixed, increment, decrement
// - Mode: normal, repeat, block; 11 prohibited
// - Side bit picks repeat or block area
// - Unit bit: byte or 16-bit word
// - One source triggers chained descriptor transfers
// - Runs at full speed always
// - Normal mode counter ends at zero
// - Interrupt every transfer or at end
`timescale 1ns/1ps
`include "transfer_controller_consts.svh"

module transfer_controller_core (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [`TC_NUM_SRC-1:0] src_irq_i,
    input wire logic [`TC_NUM_SRC-1:0] src_enable_i,
    input wire logic sw_start_i,
    input wire logic cpu_req_i,
    input wire logic cpu_boundary_i,
    input wire logic cpu_sleep_i,
    output logic cpu_ack_o,
    output logic xfc_ack_o,
    output logic ram_req_o,
    output logic ram_we_o,
    output logic [23:0] ram_addr_o,
    output logic [31:0] ram_wdata_o,
    input wire logic [31:0] ram_rdata_i,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [23:0] mem_addr_o,
    output logic mem_word_o,
    output logic [15:0] mem_wdata_o,
    input wire logic [15:0] mem_rdata_i,
    input wire logic mem_done_i,
    output logic cpu_irq_o,
    output logic act_clr_o,
    output logic [3:0] act_clr_chan_o
);

    transfer_controller_pkg::tc_core_t cur_ff;
    transfer_controller_pkg::tc_core_t nxt_ff;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_out_data;
    logic xfc_ack;
    logic cpu_ack;
    logic [`TC_NUM_SRC-1:0] pending;

    // Arbiter keeps the controller ahead of the CPU
    tc_bus_arbiter u_arb (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .xfc_req_i(cur_ff.bus_req),
        .cpu_req_i(cpu_req_i),
        .cpu_boundary_i(cpu_boundary_i),
        .cpu_sleep_i(cpu_sleep_i),
        .xfc_ack_o(xfc_ack),
        .cpu_ack_o(cpu_ack)
    );

    // Read data waits here until the write side drains it
    tc_fifo #(
        .WIDTH(`TC_FIFO_WIDTH),
        .DEPTH(`TC_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(mem_rdata_i),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // Buffer handshakes follow the bus strobes
    assign pending = src_irq_i & src_enable_i;
    assign fifo_in_valid = (cur_ff.st == transfer_controller_pkg::ST_READ) && cur_ff.mem_rd
        && mem_done_i;
    assign fifo_out_ready = (cur_ff.st == transfer_controller_pkg::ST_WRITE) && !cur_ff.mem_wr;

    // Outputs straight from flip-flops
    assign cpu_ack_o = cpu_ack;
    assign xfc_ack_o = xfc_ack;
    assign ram_req_o = cur_ff.ram_req;
    assign ram_we_o = cur_ff.ram_we;
    assign ram_addr_o = cur_ff.ram_addr;
    assign ram_wdata_o = cur_ff.ram_wdata;
    assign mem_rd_o = cur_ff.mem_rd;
    assign mem_wr_o = cur_ff.mem_wr;
    assign mem_addr_o = cur_ff.mem_addr;
    assign mem_word_o = cur_ff.mem_word;
    assign mem_wdata_o = cur_ff.mem_wdata;
    assign cpu_irq_o = cur_ff.cpu_irq;
    assign act_clr_o = cur_ff.act_clr;
    assign act_clr_chan_o = cur_ff.act_clr_chan;

    // Pointer step of one unit: 1 for a byte, 2 for a word
    function automatic logic [23:0] unit_step(input logic word);
        unit_step = word ? 24'h000002 : 24'h000001;
    endfunction : unit_step

    // Apply a two-bit stepping code to a pointer
    function automatic logic [23:0] step_ptr(
        input logic [23:0] ptr,
        input logic [1:0] code,
        input logic [23:0] amt
    );
        if (!code[1]) begin
            step_ptr = ptr;
        end else if (code[0]) begin
            step_ptr = ptr - amt;
        end else begin
            step_ptr = ptr + amt;
        end
    endfunction : step_ptr

    // Lowest-numbered enabled source wins; software comes last
    function automatic logic [3:0] pick_chan(input logic [`TC_NUM_SRC-1:0] req);
        logic [3:0] c;
        c = `TC_SW_CHAN;
        for (int i = `TC_NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                c = 4'(i);
            end
        end
        pick_chan = c;
    endfunction : pick_chan

    logic [1:0] kind;
    logic side_src;
    logic word;
    logic [1:0] src_code;
    logic [1:0] dst_code;
    logic [23:0] step;
    logic [23:0] area_len;
    logic [23:0] src_moved;
    logic [23:0] dst_moved;
    logic [7:0] low_left;
    logic [15:0] full_left;
    logic [15:0] blk_left;
    logic unit_end;
    logic seq_end;
    logic every;
    logic chain;

    // Decode of the loaded mode and the effect of finishing one unit
    always_comb begin
        kind = cur_ff.mode_a[`TC_KIND_HI:`TC_KIND_LO];
        side_src = cur_ff.mode_a[`TC_SIDE_BIT];
        word = cur_ff.mode_a[`TC_UNIT_BIT];
        src_code = cur_ff.mode_a[`TC_SRC_STEP_HI:`TC_SRC_STEP_LO];
        dst_code = cur_ff.mode_a[`TC_DST_STEP_HI:`TC_DST_STEP_LO];
        every = cur_ff.mode_b[`TC_EVERY_BIT];
        chain = cur_ff.mode_b[`TC_CHAIN_BIT];
        step = unit_step(word);
        // Length of a repeat or block area, used to walk the pointer back
        area_len = word ? {15'h0000, cur_ff.count_a[15:8], 1'b0}
            : {16'h0000, cur_ff.count_a[15:8]};
        src_moved = step_ptr(cur_ff.src_ptr, src_code, step);
        dst_moved = step_ptr(cur_ff.dst_ptr, dst_code, step);
        low_left = cur_ff.count_a[7:0] - 8'h01;
        full_left = cur_ff.count_a - 16'h0001;
        blk_left = cur_ff.count_b - 16'h0001;
        unit_end = (low_left == 8'h00);
        case (kind)
            `TC_KIND_NORMAL: seq_end = (full_left == 16'h0000);
            `TC_KIND_BLOCK: seq_end = unit_end && (blk_left == 16'h0000);
            default: seq_end = 1'b0; // Repeat never runs out
        endcase
    end

    // Main sequence: grant, load, move, write back, release
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.act_clr = 1'b0;
        nxt_ff.cpu_irq = 1'b0;
        nxt_ff.ram_req = 1'b0;
        nxt_ff.ram_we = 1'b0;
        case (cur_ff.st)
            transfer_controller_pkg::ST_IDLE: begin
                if ((|pending) || sw_start_i) begin
                    nxt_ff.chan = pick_chan(pending);
                    nxt_ff.desc_addr = `TC_RAM_WIN_LO
                        + {16'h0000, pick_chan(pending), 4'h0};
                    nxt_ff.bus_req = 1'b1;
                    nxt_ff.st = transfer_controller_pkg::ST_GRANT;
                end
            end
            transfer_controller_pkg::ST_GRANT: begin
                // Bus is ours only while the acknowledge stands
                if (xfc_ack) begin
                    nxt_ff.idx = 3'h0;
                    nxt_ff.st = transfer_controller_pkg::ST_LOAD;
                end
            end
            transfer_controller_pkg::ST_LOAD: begin
                // Even steps issue a one-state read, odd steps capture it
                nxt_ff.idx = cur_ff.idx + 3'h1;
                if (!cur_ff.idx[0]) begin
                    nxt_ff.ram_req = 1'b1;
                    nxt_ff.ram_addr = cur_ff.desc_addr
                        + (`TC_DESC_WORD * {22'h000000, cur_ff.idx[2:1]});
                end else begin
                    case (cur_ff.idx[2:1])
                        2'h0: begin
                            nxt_ff.mode_a = ram_rdata_i[31:24];
                            nxt_ff.src_ptr = ram_rdata_i[23:0];
                        end
                        2'h1: begin
                            nxt_ff.mode_b = ram_rdata_i[31:24];
                            nxt_ff.dst_ptr = ram_rdata_i[23:0];
                        end
                        default: begin
                            nxt_ff.count_a = ram_rdata_i[31:16];
                            nxt_ff.count_b = ram_rdata_i[15:0];
                        end
                    endcase
                end
                if (cur_ff.idx == `TC_LAST_IDX) begin
                    nxt_ff.st = transfer_controller_pkg::ST_READ;
                end
            end
            transfer_controller_pkg::ST_READ: begin
                // No read starts unless the buffer can take its data
                if (!cur_ff.mem_rd && fifo_in_ready) begin
                    nxt_ff.mem_rd = 1'b1;
                    nxt_ff.mem_addr = cur_ff.src_ptr;
                    nxt_ff.mem_word = word;
                end else if (cur_ff.mem_rd && mem_done_i) begin
                    nxt_ff.mem_rd = 1'b0;
                    nxt_ff.st = transfer_controller_pkg::ST_WRITE;
                end
            end
            transfer_controller_pkg::ST_WRITE: begin
                if (!cur_ff.mem_wr && fifo_out_valid) begin
                    nxt_ff.mem_wr = 1'b1;
                    nxt_ff.mem_addr = cur_ff.dst_ptr;
                    nxt_ff.mem_wdata = fifo_out_data;
                end else if (cur_ff.mem_wr && mem_done_i) begin
                    nxt_ff.mem_wr = 1'b0;
                    nxt_ff.src_ptr = src_moved;
                    nxt_ff.dst_ptr = dst_moved;
                    nxt_ff.st = transfer_controller_pkg::ST_STORE;
                    case (kind)
                        `TC_KIND_NORMAL: begin
                            nxt_ff.count_a = full_left;
                        end
                        default: begin
                            nxt_ff.count_a[7:0] = low_left;
                            if (unit_end) begin
                                // Area finished: reload and walk back the area side
                                nxt_ff.count_a[7:0] = cur_ff.count_a[15:8];
                                if (side_src) begin
                                    nxt_ff.src_ptr = step_ptr(src_moved,
                                        {src_code[1], ~src_code[0]}, area_len);
                                end else begin
                                    nxt_ff.dst_ptr = step_ptr(dst_moved,
                                        {dst_code[1], ~dst_code[0]}, area_len);
                                end
                                if (kind == `TC_KIND_BLOCK) begin
                                    nxt_ff.count_b = blk_left;
                                end
                            end else if (kind == `TC_KIND_BLOCK) begin
                                // A block runs to its end within one activation
                                nxt_ff.st = transfer_controller_pkg::ST_READ;
                            end
                        end
                    endcase
                    if (nxt_ff.st == transfer_controller_pkg::ST_STORE) begin
                        nxt_ff.cpu_irq = (seq_end || every) && !chain;
                        nxt_ff.act_clr = (seq_end || every) && !chain;
                        nxt_ff.act_clr_chan = cur_ff.chan;
                        nxt_ff.chain_next = chain;
                        nxt_ff.idx = 3'h0;
                    end
                end
            end
            transfer_controller_pkg::ST_STORE: begin
                // Updated set goes back to RAM, one word per state
                nxt_ff.idx = cur_ff.idx + 3'h1;
                nxt_ff.ram_req = 1'b1;
                nxt_ff.ram_we = 1'b1;
                nxt_ff.ram_addr = cur_ff.desc_addr
                    + (`TC_DESC_WORD * {22'h000000, cur_ff.idx[1:0]});
                case (cur_ff.idx[1:0])
                    2'h0: nxt_ff.ram_wdata = {cur_ff.mode_a, cur_ff.src_ptr};
                    2'h1: nxt_ff.ram_wdata = {cur_ff.mode_b, cur_ff.dst_ptr};
                    default: nxt_ff.ram_wdata = {cur_ff.count_a, cur_ff.count_b};
                endcase
                if (cur_ff.idx == 3'h2) begin
                    if (cur_ff.chain_next) begin
                        // Next set follows; the bus stays ours
                        nxt_ff.desc_addr = cur_ff.desc_addr + `TC_DESC_STRIDE;
                        nxt_ff.idx = 3'h0;
                        nxt_ff.st = transfer_controller_pkg::ST_LOAD;
                    end else begin
                        nxt_ff.bus_req = 1'b0;
                        nxt_ff.st = transfer_controller_pkg::ST_END;
                    end
                end
            end
            transfer_controller_pkg::ST_END: begin
                // Wait for the acknowledge to fall so a new start is clean
                if (!xfc_ack) begin
                    nxt_ff.st = transfer_controller_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_ff = '0;
                nxt_ff.st = transfer_controller_pkg::ST_IDLE;
            end
        endcase
    end

    // Always on the full-rate clock; no divided enable reaches this block
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_ff <= '0;
            cur_ff.st <= transfer_controller_pkg::ST_IDLE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

endmodule : transfer_controller_core

// file: core/transfer_controller_consts.svh
`ifndef TRANSFER_CONTROLLER_CONSTS_SVH
`define TRANSFER_CONTROLLER_CONSTS_SVH

// Descriptor window in on-chip RAM, reached over a 32-bit path
`define TC_RAM_WIN_LO 24'hFFEC00
`define TC_RAM_WIN_HI 24'hFFEFFF
// Byte distance between descriptor sets; a chained set follows directly
`define TC_DESC_STRIDE 24'h000010
`define TC_DESC_WORD 24'h000004
// Index of the last load half-step (three words, issue and capture); store ends at index 2
`define TC_LAST_IDX 3'h5

// Mode register field positions
`define TC_SRC_STEP_HI 7
`define TC_SRC_STEP_LO 6
`define TC_DST_STEP_HI 5
`define TC_DST_STEP_LO 4
`define TC_KIND_HI 3
`define TC_KIND_LO 2
`define TC_SIDE_BIT 1
`define TC_UNIT_BIT 0
// Second mode register flags
`define TC_CHAIN_BIT 7
`define TC_EVERY_BIT 6

// Transfer kinds
`define TC_KIND_NORMAL 2'h0
`define TC_KIND_REPEAT 2'h1
`define TC_KIND_BLOCK 2'h2

// Software activation occupies the channel after the interrupt sources
`define TC_NUM_SRC 8
`define TC_SW_CHAN 4'h8

// Data buffer shape
`define TC_FIFO_WIDTH 16
`define TC_FIFO_DEPTH 16

`endif

// file: core/transfer_controller_pkg.sv
package transfer_controller_pkg;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_GRANT = 7'h02,
        ST_LOAD  = 7'h04,
        ST_READ  = 7'h08,
        ST_WRITE = 7'h10,
        ST_STORE = 7'h20,
        ST_END   = 7'h40
    } tc_state_t;

    typedef struct packed {
        tc_state_t st;
        logic [3:0] chan;
        logic [23:0] desc_addr;
        logic [2:0] idx;
        logic [7:0] mode_a;
        logic [7:0] mode_b;
        logic [23:0] src_ptr;
        logic [23:0] dst_ptr;
        logic [15:0] count_a;
        logic [15:0] count_b;
        logic bus_req;
        logic ram_req;
        logic ram_we;
        logic [23:0] ram_addr;
        logic [31:0] ram_wdata;
        logic mem_rd;
        logic mem_wr;
        logic [23:0] mem_addr;
        logic mem_word;
        logic [15:0] mem_wdata;
        logic cpu_irq;
        logic act_clr;
        logic [3:0] act_clr_chan;
        logic chain_next;
    } tc_core_t;

    typedef struct packed {
        logic xfc_ack;
        logic cpu_ack;
    } arb_state_t;

endpackage : transfer_controller_pkg

// file: core/tc_fifo.sv
`timescale 1ns/1ps

module tc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] fill;
    } fifo_state_t;

    fifo_state_t cur_ff;
    fifo_state_t nxt_ff;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Full and empty come straight from the fill count, so they never lie
    assign in_ready_o = (cur_ff.fill != (AW+1)'(DEPTH));
    assign out_valid_o = (cur_ff.fill != '0);
    assign out_data_o = mem[cur_ff.rd_ptr];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Pointer and fill update
    always_comb begin
        nxt_ff = cur_ff;
        if (push) begin
            nxt_ff.wr_ptr = cur_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_ff.rd_ptr = cur_ff.rd_ptr + 1'b1;
        end
        nxt_ff.fill = cur_ff.fill + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[cur_ff.wr_ptr] <= in_data_i;
        end
    end

endmodule : tc_fifo

// file: core/tc_bus_arbiter.sv
`timescale 1ns/1ps

module tc_bus_arbiter (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic xfc_req_i,
    input wire logic cpu_req_i,
    input wire logic cpu_boundary_i,
    input wire logic cpu_sleep_i,
    output logic xfc_ack_o,
    output logic cpu_ack_o
);

    transfer_controller_pkg::arb_state_t cur_ff;
    transfer_controller_pkg::arb_state_t nxt_ff;

    assign xfc_ack_o = cur_ff.xfc_ack;
    assign cpu_ack_o = cur_ff.cpu_ack;

    // The CPU yields only between whole bus cycles, or at once when asleep
    always_comb begin
        nxt_ff = cur_ff;
        if (cur_ff.xfc_ack) begin
            if (!xfc_req_i) begin
                nxt_ff.xfc_ack = 1'b0;
            end
        end else if (xfc_req_i && (!cur_ff.cpu_ack || cpu_boundary_i || cpu_sleep_i)) begin
            nxt_ff.xfc_ack = 1'b1;
            nxt_ff.cpu_ack = 1'b0;
        end else begin
            nxt_ff.cpu_ack = cpu_req_i;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

endmodule : tc_bus_arbiter

// file: bench/tc_core_checker.sv
`timescale 1ns/1ps
`include "transfer_controller_consts.svh"

module tc_core_checker (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sw_start_i,
    input wire logic cpu_boundary_i,
    input wire logic cpu_sleep_i,
    input wire logic cpu_ack_o,
    input wire logic xfc_ack_o,
    input wire logic ram_req_o,
    input wire logic ram_we_o,
    input wire logic [23:0] ram_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic mem_done_i,
    input wire logic cpu_irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Bus ownership is exclusive and held for every descriptor and data access
    a_ack_exclusive: assert property (!(xfc_ack_o && cpu_ack_o))
        else $error("both masters own the bus");
    a_ram_owned: assert property (ram_req_o |-> xfc_ack_o)
        else $error("descriptor access without bus ownership");
    a_data_owned: assert property (mem_rd_o || mem_wr_o |-> xfc_ack_o)
        else $error("data access without bus ownership");
    // Descriptor words stay inside the reserved window, one state each
    a_ram_window: assert property (ram_req_o |->
        ram_addr_o >= `TC_RAM_WIN_LO && ram_addr_o <= `TC_RAM_WIN_HI)
        else $error("descriptor address outside window");
    a_load_state: assert property (ram_req_o && !ram_we_o |=> !ram_req_o)
        else $error("descriptor read not followed by capture state");
    a_strobe_hold: assert property (mem_rd_o && !mem_done_i |=> mem_rd_o)
        else $error("read strobe dropped before done");
    a_irq_pulse: assert property (cpu_irq_o |=> !cpu_irq_o)
        else $error("interrupt request longer than one cycle");
    // A waking CPU may only yield between whole bus cycles
    a_cpu_yield: assert property ($fell(cpu_ack_o) |->
        $past(cpu_boundary_i) || $past(cpu_sleep_i))
        else $error("bus taken inside a split CPU cycle");
    a_sleep_grant: assert property ($rose(sw_start_i) && cpu_sleep_i && !xfc_ack_o
        |-> ##[1:4] xfc_ack_o)
        else $error("sleeping CPU did not yield promptly");

    c_grant: cover property ($rose(xfc_ack_o));
    c_irq: cover property (cpu_irq_o);
    c_store: cover property (ram_req_o && ram_we_o);
endmodule : tc_core_checker

bind transfer_controller_core tc_core_checker i_chk (.*);

// file: bench/tc_mem_model.sv
`timescale 1ns/1ps

module tc_mem_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic ram_req_i,
    input wire logic ram_we_i,
    input wire logic [23:0] ram_addr_i,
    input wire logic [31:0] ram_wdata_i,
    output logic [31:0] ram_rdata_o,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [23:0] mem_addr_i,
    input wire logic mem_word_i,
    input wire logic [15:0] mem_wdata_i,
    output logic [15:0] mem_rdata_o,
    output logic mem_done_o
);
    logic [31:0] ram [256];
    logic [7:0] mem [256];
    logic busy;
    logic [1:0] cnt;
    wire logic [7:0] a0 = mem_addr_i[7:0];
    wire logic [7:0] a1 = mem_addr_i[7:0] + 8'h01;

    // One-state descriptor read; idle data is inverted
    assign ram_rdata_o = (ram_req_i && !ram_we_i) ? ram[ram_addr_i[9:2]]
        : ~ram[ram_addr_i[9:2]];
    always @(posedge core_clk_i) begin
        if (ram_req_i && ram_we_i) ram[ram_addr_i[9:2]] <= ram_wdata_i;
    end

    // Data side: fixed latency, longer when slow, done pulses once per strobe
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            cnt <= 2'h0;
            mem_done_o <= 1'b0;
            mem_rdata_o <= 16'h0000;
        end else begin
            mem_done_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
            if ((mem_rd_i || mem_wr_i) && !busy && !mem_done_o) begin
                busy <= 1'b1;
                cnt <= slow_i ? 2'h3 : 2'h0;
            end else if (busy && cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end else if (busy) begin
                busy <= 1'b0;
                mem_done_o <= 1'b1;
                mem_rdata_o <= {mem_word_i ? mem[a1] : 8'h00, mem[a0]};
                if (mem_wr_i) begin
                    mem[a0] <= mem_wdata_i[7:0];
                    if (mem_word_i) mem[a1] <= mem_wdata_i[15:8];
                end
            end
        end
    end
endmodule : tc_mem_model

// file: bench/test_transfer_controller_core.sv
`timescale 1ns/1ps
`include "transfer_controller_consts.svh"

module test_transfer_controller_core;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [`TC_NUM_SRC-1:0] src_irq_i = 8'h00;
    logic [`TC_NUM_SRC-1:0] src_enable_i = 8'h00;
    logic sw_start_i = 1'b0;
    logic cpu_req_i = 1'b1;
    logic cpu_boundary_i = 1'b0;
    logic cpu_sleep_i = 1'b1;
    logic slow_i = 1'b0;
    logic cpu_ack_o, xfc_ack_o, ram_req_o, ram_we_o, mem_rd_o, mem_wr_o, mem_word_o;
    logic [23:0] ram_addr_o, mem_addr_o;
    logic [31:0] ram_wdata_o, ram_rdata_i;
    logic [15:0] mem_wdata_o, mem_rdata_i;
    logic mem_done_i, cpu_irq_o, act_clr_o;
    logic [3:0] act_clr_chan_o;
    logic [3:0] clr_chan = 4'h0;
    int n_errors = 0;
    int samples_checked = 0;
    int irq_cnt = 0;
    int clr_cnt = 0;

    always #5 core_clk_i = ~core_clk_i;

    transfer_controller_core i_dut (.*);

    tc_mem_model i_mem (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow_i),
        .ram_req_i(ram_req_o), .ram_we_i(ram_we_o), .ram_addr_i(ram_addr_o),
        .ram_wdata_i(ram_wdata_o), .ram_rdata_o(ram_rdata_i), .mem_rd_i(mem_rd_o),
        .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o), .mem_word_i(mem_word_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .mem_done_o(mem_done_i));

    // CPU keeps splitting cycles so only every other edge is a boundary
    always @(posedge core_clk_i) begin
        cpu_boundary_i <= ~cpu_boundary_i;
        if (cpu_irq_o === 1'b1) irq_cnt <= irq_cnt + 1;
        if (act_clr_o === 1'b1) begin
            src_irq_i <= 8'h00;
            sw_start_i <= 1'b0;
            clr_chan <= act_clr_chan_o;
            clr_cnt <= clr_cnt + 1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task automatic put(input int chan, input logic [31:0] w0, w1, w2);
        i_mem.ram[chan * 4] = w0;
        i_mem.ram[chan * 4 + 1] = w1;
        i_mem.ram[chan * 4 + 2] = w2;
    endtask : put

    // Raise an activation and wait until the clear pulse and bus release
    task automatic go(input logic sw, input logic [7:0] irq);
        int i;
        int c0;
        i = 0;
        c0 = clr_cnt;
        sw_start_i <= sw;
        src_irq_i <= irq;
        while (clr_cnt == c0 && i < 300) begin
            @(posedge core_clk_i);
            i++;
        end
        while (xfc_ack_o !== 1'b0 && i < 300) begin
            @(posedge core_clk_i);
            i++;
        end
        repeat (4) @(posedge core_clk_i);
        check(i < 300, 1'b1);
    endtask : go

    initial begin
        repeat (3000) @(posedge core_clk_i);
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        // Normal byte copy, source up, destination down, three units
        put(8, 32'hB0000010, 32'h00000042, 32'h00030000);
        i_mem.mem[8'h10] = 8'hA1;
        i_mem.mem[8'h11] = 8'hA2;
        i_mem.mem[8'h12] = 8'hA3;
        go(1'b1, 8'h00);
        check(i_mem.mem[8'h42], 8'hA1);
        check(i_mem.mem[8'h40], 8'hA3);
        check(i_mem.ram[32], 32'hB0000013);
        check(i_mem.ram[33], 32'h0000003F);
        check(i_mem.ram[34][31:16], 16'h0000);
        check(clr_chan, `TC_SW_CHAN);
        check(irq_cnt, 1);
        // Awake CPU, slow memory, word unit, fixed source, enabled source only
        cpu_sleep_i <= 1'b0;
        src_enable_i <= 8'h04;
        slow_i <= 1'b1;
        put(2, 32'h21000020, 32'h40000060, 32'h00020000);
        i_mem.mem[8'h20] = 8'h34;
        i_mem.mem[8'h21] = 8'h12;
        go(1'b0, 8'h05);
        check({i_mem.mem[8'h61], i_mem.mem[8'h60]}, 16'h1234);
        check(i_mem.ram[8], 32'h21000020);
        check(i_mem.ram[9], 32'h40000062);
        check(i_mem.ram[10][31:16], 16'h0001);
        check(clr_chan, 4'h2);
        check(irq_cnt, 2);
        check(cpu_ack_o, 1'b1);
        // Block of two bytes, destination is the block area
        cpu_sleep_i <= 1'b1;
        slow_i <= 1'b0;
        put(8, 32'hA8000080, 32'h00000090, 32'h02020001);
        i_mem.mem[8'h80] = 8'hC1;
        i_mem.mem[8'h81] = 8'hC2;
        go(1'b1, 8'h00);
        check(i_mem.mem[8'h91], 8'hC2);
        check(i_mem.ram[32], 32'hA8000082);
        check(i_mem.ram[33], 32'h00000090);
        check(i_mem.ram[34][15:0], 16'h0000);
        check(irq_cnt, 3);
        // Repeat area of two bytes on the destination side wraps back
        put(8, 32'h24000080, 32'h400000A0, 32'h02020000);
        go(1'b1, 8'h00);
        go(1'b1, 8'h00);
        check(i_mem.mem[8'hA1], 8'hC1);
        check(i_mem.ram[33], 32'h400000A0);
        check(i_mem.ram[34][31:16], 16'h0202);
        check(irq_cnt, 5);
        // Two chained sets
        put(8, 32'h20000080, 32'h800000B0, 32'h00010000);
        put(9, 32'h20000081, 32'h000000B8, 32'h00010000);
        go(1'b1, 8'h00);
        check({i_mem.mem[8'hB8], 8'(irq_cnt)}, 16'hC206);
        end_sim();
    end
endmodule : test_transfer_controller_core
